// >>> design/rtc_core.sv
// BCD clock/calendar register core with serial slave port and user RAM
// Function
// RQ1 - After START and matching address, transfer successive locations, pointer advancing per byte.
// RQ2 - Refuse all register access while primary supply is below threshold.
// RQ3 - Re-enable access only after recovery delay once supply returns.
// RQ4 - First power-up loads 01/01/00, weekday 01, 00:00:00, halt cleared.
// RQ5 - No backup draw until supply has exceeded threshold once.
// RQ6 - Filter oscillator glitches under 5us while supply is good.
// RQ7 - Locations 0-7 are clock and control, 8-3F are 56 RAM bytes.
// RQ8 - Pointer wraps from 3F to 0 during multibyte access.
// RQ9 - Snapshot time into user buffers on START and pointer wrap; read buffers.
// RQ10 - All time fields held and counted in BCD tens and units.
// RQ11 - Halt bit in register 0 bit 7 stops oscillator and counting; code stops counting only, wave pin still passes oscillator in rate 11.
// RQ12 - Weekday counts cyclically 1 to 7 at midnight.
// RQ13 - Date rolls at true month end, with leap-year February.
// RQ14 - Any seconds write resets the sub-second countdown chain.
// RQ15 - Written bytes commit at the acknowledge.
// RQ16 - Master writes remaining time registers within 1 second of seconds.
// RQ17 - 1Hz wave goes high 500ms after seconds write.
// RQ18 - Hours bit 6 selects 12-hour mode; bit 5 is PM or twenties.
// RQ19 - Master rewrites hours after changing 12/24 selection.
// RQ20 - Master writes only in-range values.
// RQ21 - Fixed-zero bits always read zero.
// RQ22 - Respond only to address D0h.
// RQ23 - Oscillator-stopped flag sets on run-to-stop, clears only by writing zero.
// RQ24 - 12-hour mode counts 12,1..11, PM toggles at 11 to 12.
// RQ25 - Supply loss mid-transfer abandons transfer and releases data line.
`timescale 1ns/1ps
`default_nettype none
module rtc_core #(
	parameter int unsigned REC_US = 2000
) (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	input  wire logic osc_i,
	input  wire logic vcc_ok_i,
	input  wire logic vcc_gt_bat_i,
	output logic      backup_power_o,
	output logic      access_enabled_o,
	output logic      wave_or_ref_pin_o,
	output logic      wave_or_ref_pin_oe_o
);
	import rtc_pkg::*;

	localparam int unsigned REC_CYC = (REC_US * 1000) / CLK_NS;

	if (REC_CYC < 1 || REC_CYC > 24'hFF_FFFF) begin : g_chk
		$error("recovery delay does not fit the counter");
	end

	typedef struct packed {
		rtc_st_e          st;
		logic [3:0]       bits;
		logic [7:0]       sh;
		logic             rw;
		logic             ptr_set;
		logic [5:0]       ptr;
		logic             sda_oe;
		logic [2:0]       scl_s;
		logic [2:0]       sda_s;
		logic [1:0]       vok_s;
		logic [1:0]       gtb_s;
		logic [23:0]      rec_cnt;
		logic             acc_en;
		logic             unsealed;
		logic             backup;
		logic [14:0]      presc;
		logic [6:0][7:0]  tm;
		logic [6:0][7:0]  shd;
		logic [7:0]       ctrl;
		logic [55:0][7:0] ram;
		logic             wave_oe;
	} rtc_core_s;

	rtc_core_s r;
	rtc_core_s n;
	rtc_osc_if osc ();

	rtc_osc_filter u_filt (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.osc_i  (osc_i),
		.osc    (osc.src)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top, input logic [7:0] lo);
		if (v == top) begin
			bcd_inc = {1'b1, lo};
		end else if (v[3:0] == 4'h9) begin
			bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h02: month_len = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
			default: month_len = 8'h31;
		endcase
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic       scl_rise;
		logic       scl_fall;
		logic       start_c;
		logic       stop_c;
		logic       wr;
		logic       adv;
		logic       dc;
		logic [8:0] c;
		logic [7:0] rd;
		logic       wlvl;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_c = 1'b0;
		stop_c = 1'b0;
		wr = 1'b0;
		adv = 1'b0;
		dc = 1'b0;
		c = 9'h000;
		rd = 8'h00;
		wlvl = 1'b0;
		n = r;
		n.scl_s = {r.scl_s[1:0], scl_i};
		n.sda_s = {r.sda_s[1:0], sda_i};
		n.vok_s = {r.vok_s[0], vcc_ok_i};
		n.gtb_s = {r.gtb_s[0], vcc_gt_bat_i};
		scl_rise = r.scl_s[1] & ~r.scl_s[2];
		scl_fall = ~r.scl_s[1] & r.scl_s[2];
		start_c = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
		stop_c = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];

		// RQ3 recovery delay
		if (!r.vok_s[1]) begin
			n.acc_en = 1'b0;
			n.rec_cnt = 24'h00_0000;
		end else if (!r.acc_en) begin
			n.rec_cnt = r.rec_cnt + 24'h00_0001;
			n.acc_en = (r.rec_cnt == 24'(REC_CYC - 1));
		end
		// RQ5 freshness seal
		if (r.vok_s[1]) begin
			n.unsealed = 1'b1;
		end
		n.backup = r.unsealed & ~r.vok_s[1] & ~r.gtb_s[1];

		// Read source: buffered time, control, or RAM
		if (r.ptr == REG_CTRL) begin
			rd = r.ctrl;
		end else if (r.ptr < REG_CTRL) begin
			rd = r.shd[r.ptr[2:0]];
		end else begin
			rd = r.ram[6'(r.ptr - RAM_BASE)];
		end

		// ************************************************************
		// Serial slave
		// ************************************************************
		if (!r.acc_en) begin
			// RQ2 RQ25 abandon and release
			n.st = ST_IDLE;
			n.sda_oe = 1'b0;
		end else if (start_c) begin
			n.st = ST_ADDR;
			n.bits = 4'h0;
			n.sda_oe = 1'b0;
		end else if (stop_c) begin
			n.st = ST_IDLE;
			n.sda_oe = 1'b0;
		end else begin
			case (r.st)
				ST_ADDR, ST_WR: begin
					if (scl_rise && r.bits != 4'h8) begin
						n.sh = {r.sh[6:0], r.sda_s[1]};
						n.bits = r.bits + 4'h1;
					end else if (scl_fall && r.bits == 4'h8) begin
						if (r.st == ST_WR) begin
							// RQ15 commit on ack
							n.sda_oe = 1'b1;
							n.st = ST_WACK;
							wr = 1'b1;
						// RQ22 address match
						end else if (r.sh[7:1] == DEV_ADDR[7:1]) begin
							n.sda_oe = 1'b1;
							n.rw = r.sh[0];
							n.st = ST_AACK;
						end else begin
							n.st = ST_IDLE;
						end
					end
				end
				ST_AACK, ST_WACK, ST_RACK: begin
					if (r.st == ST_RACK && scl_rise && r.sda_s[1]) begin
						n.st = ST_IDLE;
					end else if (scl_fall) begin
						n.bits = 4'h0;
						n.sda_oe = 1'b0;
						n.st = ST_WR;
						n.ptr_set = (r.st == ST_AACK);
						if (r.st == ST_RACK || (r.st == ST_AACK && r.rw)) begin
							n.sh = rd;
							n.sda_oe = ~rd[7];
							n.bits = 4'h1;
							n.st = ST_RD;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (r.bits == 4'h8) begin
							// RQ1 advance after each byte
							n.sda_oe = 1'b0;
							n.st = ST_RACK;
							adv = 1'b1;
						end else begin
							n.sh = {r.sh[6:0], 1'b0};
							n.sda_oe = ~r.sh[6];
							n.bits = r.bits + 4'h1;
						end
					end
				end
				default: begin
					n.sda_oe = 1'b0;
				end
			endcase
		end

		// ************************************************************
		// Countdown chain and calendar
		// ************************************************************
		// RQ11 halt stops counting
		if (osc.tick && !r.tm[0][HALT_BIT]) begin
			n.presc = r.presc + 15'h0001;
			if (r.presc == PRESC_TOP) begin
				// RQ10 BCD seconds
				c = bcd_inc({1'b0, r.tm[0][6:0]}, 8'h59, 8'h00);
				n.tm[0] = c[7:0];
				if (c[8]) begin
					c = bcd_inc(r.tm[1], 8'h59, 8'h00);
					n.tm[1] = c[7:0];
					if (c[8]) begin
						// RQ18 RQ24 hour modes
						if (r.tm[2][MODE12_BIT]) begin
							if (r.tm[2][4:0] == 5'h11) begin
								n.tm[2] = {2'b01, ~r.tm[2][PM_BIT], 5'h12};
								dc = r.tm[2][PM_BIT];
							end else if (r.tm[2][4:0] == 5'h12) begin
								n.tm[2] = {r.tm[2][7:5], 5'h01};
							end else begin
								c = bcd_inc({3'b000, r.tm[2][4:0]}, 8'h12, 8'h01);
								n.tm[2] = {r.tm[2][7:5], c[4:0]};
							end
						end else begin
							c = bcd_inc({2'b00, r.tm[2][5:0]}, 8'h23, 8'h00);
							n.tm[2] = {2'b00, c[5:0]};
							dc = c[8];
						end
						if (dc) begin
							// RQ12 weekday cycle
							c = bcd_inc(r.tm[3], 8'h07, 8'h01);
							n.tm[3] = c[7:0];
							// RQ13 month end
							c = bcd_inc(r.tm[4], month_len(r.tm[5], r.tm[6]), 8'h01);
							n.tm[4] = c[7:0];
							if (c[8]) begin
								c = bcd_inc(r.tm[5], 8'h12, 8'h01);
								n.tm[5] = c[7:0];
								if (c[8]) begin
									c = bcd_inc(r.tm[6], 8'h99, 8'h00);
									n.tm[6] = c[7:0];
								end
							end
						end
					end
				end
			end
		end

		// ************************************************************
		// Register writes and pointer
		// ************************************************************
		if (wr) begin
			if (r.ptr_set) begin
				n.ptr = r.sh[5:0];
			end else begin
				adv = 1'b1;
				if (r.ptr < REG_CTRL) begin
					// RQ21 fixed zeros masked
					n.tm[r.ptr[2:0]] = r.sh & WR_MASK[r.ptr[2:0]];
					if (r.ptr == REG_SEC) begin
						// RQ14 reset countdown
						n.presc = 15'h0000;
					end
				end else if (r.ptr == REG_CTRL) begin
					n.ctrl = {r.sh[7:6], r.ctrl[OSF_BIT] & r.sh[OSF_BIT], r.sh[4],
						r.ctrl[LOS_BIT] & r.sh[LOS_BIT], r.sh[2:0]};
				end else begin
					// RQ7 user RAM
					n.ram[6'(r.ptr - RAM_BASE)] = r.sh;
				end
			end
		end
		// RQ23 set wins over clear
		if (!r.tm[0][HALT_BIT] && n.tm[0][HALT_BIT]) begin
			n.ctrl[OSF_BIT] = 1'b1;
		end
		if (adv) begin
			// RQ8 wrap to zero
			n.ptr = r.ptr + 6'h01;
		end
		// RQ9 snapshot
		if ((r.acc_en && start_c) || (adv && r.ptr == PTR_TOP)) begin
			n.shd = n.tm;
		end

		// ************************************************************
		// Wave pin, open drain
		// ************************************************************
		// RQ17 1Hz phase from chain
		case (r.ctrl[1:0])
			2'b00: wlvl = r.presc[14];
			2'b01: wlvl = r.presc[2];
			2'b10: wlvl = r.presc[1];
			default: wlvl = osc.lvl;
		endcase
		if (!r.ctrl[SQUARE_WAVE_ENABLE_BIT]) begin
			wlvl = r.ctrl[OUT_BIT];
		end
		n.wave_oe = ~wlvl & ~r.ctrl[EXT_CLOCK_INPUT_ENABLE_BIT] & ~(r.backup & ~r.ctrl[BACKUP_PIN_ENABLE_BIT]);
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
			// RQ4 first power-up values
			r.tm <= TM_RST;
			r.shd <= TM_RST;
			r.ctrl <= CTRL_RST;
			r.scl_s <= 3'b111;
			r.sda_s <= 3'b111;
		end else begin
			r <= n;
		end
	end

	assign osc.filt_en = r.vok_s[1];
	assign sda_o = 1'b0;
	assign sda_oe_o = r.sda_oe;
	assign backup_power_o = r.backup;
	assign access_enabled_o = r.acc_en;
	assign wave_or_ref_pin_o = 1'b0;
	assign wave_or_ref_pin_oe_o = r.wave_oe;
endmodule
`default_nettype wire

// >>> design/rtc_osc_filter.sv
// Oscillator input synchroniser and glitch filter
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_filter (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic osc_i,
	rtc_osc_if.src    osc
);
	import rtc_pkg::*;

	typedef struct packed {
		logic [1:0] sy;
		logic       lvl;
		logic [8:0] cnt;
		logic       tick;
	} rtc_filt_s;

	rtc_filt_s r;
	rtc_filt_s n;

	if (GLITCH_CYC < 1 || GLITCH_CYC > 511) begin : g_chk
		$error("glitch count does not fit the filter counter");
	end

	always_comb begin
		n = r;
		n.sy = {r.sy[0], osc_i};
		n.tick = 1'b0;
		if (r.sy[1] != r.lvl) begin
			// RQ6 glitch filter
			if (!osc.filt_en || r.cnt == 9'(GLITCH_CYC - 1)) begin
				n.lvl = r.sy[1];
				n.cnt = 9'h000;
				n.tick = r.sy[1];
			end else begin
				n.cnt = r.cnt + 9'h001;
			end
		end else begin
			n.cnt = 9'h000;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign osc.tick = r.tick;
	assign osc.lvl  = r.lvl;
endmodule
`default_nettype wire

// >>> design/rtc_osc_if.sv
// Carrier between the oscillator filter and the register core
`timescale 1ns/1ps
`default_nettype none
interface rtc_osc_if;
	logic filt_en;
	logic tick;
	logic lvl;
	modport src (input filt_en, output tick, output lvl);
	modport snk (output filt_en, input tick, input lvl);
endinterface
`default_nettype wire

// >>> design/rtc_pkg.sv
// Shared constants and types of the BCD clock/calendar register core
package rtc_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_NS     = 20;
	localparam int unsigned GLITCH_NS  = 5000;
	localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [14:0] PRESC_TOP  = 15'h7FFF;

	// ****************************************************************
	// Bus address and register map
	// ****************************************************************
	localparam logic [7:0] DEV_ADDR  = 8'hD0;
	localparam logic [5:0] REG_SEC   = 6'h00;
	localparam logic [5:0] REG_HOUR  = 6'h02;
	localparam logic [5:0] REG_CTRL  = 6'h07;
	localparam logic [5:0] RAM_BASE  = 6'h08;
	localparam logic [5:0] PTR_TOP   = 6'h3F;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned HALT_BIT   = 7;
	localparam int unsigned MODE12_BIT = 6;
	localparam int unsigned PM_BIT     = 5;
	localparam int unsigned OUT_BIT    = 7;
	localparam int unsigned EXT_CLOCK_INPUT_ENABLE_BIT   = 6;
	localparam int unsigned OSF_BIT    = 5;
	localparam int unsigned SQUARE_WAVE_ENABLE_BIT   = 4;
	localparam int unsigned LOS_BIT    = 3;
	localparam int unsigned BACKUP_PIN_ENABLE_BIT  = 2;

	// ****************************************************************
	// Reset values and write masks, index 6 = year .. 0 = seconds
	// ****************************************************************
	localparam logic [7:0]      CTRL_RST = 8'hBF;
	localparam logic [6:0][7:0] TM_RST   = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	localparam logic [6:0][7:0] WR_MASK  = {8'hFF, 8'h1F, 8'h3F, 8'h07, 8'h7F, 8'h7F, 8'hFF};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_WR   = 3'b011,
		ST_WACK = 3'b100,
		ST_RD   = 3'b101,
		ST_RACK = 3'b110
	} rtc_st_e;

endpackage

// >>> testbench/rtc_core_properties.sv
// Pin-level checks of the register core, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module rtc_core_properties
	import rtc_pkg::*;
#(
	parameter int unsigned REC_US = 2000
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic sda_oe_o,
	input wire logic osc_i,
	input wire logic vcc_ok_i,
	input wire logic backup_power_o,
	input wire logic access_enabled_o,
	input wire logic wave_or_ref_pin_oe_o
);
	localparam int unsigned REC_CYC = REC_US * 1000 / 20;
	logic [19:0] vcnt;
	logic [19:0] ocnt;
	logic        osc_q;
	logic        seen;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	// Saturating run lengths of good supply and steady oscillator
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vcnt  <= '0;
			ocnt  <= '0;
			osc_q <= 1'b0;
			seen  <= 1'b0;
		end else begin
			vcnt  <= !vcc_ok_i ? '0 : vcnt + 20'(~&vcnt);
			ocnt  <= (osc_i != osc_q) ? '0 : ocnt + 20'(~&ocnt);
			osc_q <= osc_i;
			seen  <= seen | vcc_ok_i;
		end
	end
	chk_closed_quiet: assert property (!access_enabled_o [*3] |-> !sda_oe_o)
		else $error("data line held while access closed");
	chk_access_drop: assert property (!vcc_ok_i [*4] |-> !access_enabled_o)
		else $error("access open on bad supply");
	chk_rec_early: assert property ($rose(access_enabled_o) |-> vcnt >= REC_CYC)
		else $error("access opened before recovery");
	chk_rec_late: assert property (vcnt == REC_CYC + 8 |-> access_enabled_o)
		else $error("access not opened after recovery");
	chk_fresh_seal: assert property (backup_power_o |-> seen)
		else $error("cell used before first good supply");
	chk_primary_pwr: assert property (vcc_ok_i [*4] |-> !backup_power_o)
		else $error("cell used on good supply");
	chk_ack_scl_low: assert property ($changed(sda_oe_o) && vcnt > 6 |-> !scl_i)
		else $error("data line moved while clock high");
	chk_glitch_min: assert property ($changed(wave_or_ref_pin_oe_o) && vcnt > 400 |-> ocnt >= GLITCH_CYC)
		else $error("short oscillator pulse passed");
	chk_glitch_pass: assert property (ocnt == GLITCH_CYC + 8 && vcnt > 400 |-> wave_or_ref_pin_oe_o == !osc_i)
		else $error("steady oscillator level not passed");
endmodule
bind rtc_core rtc_core_properties #(.REC_US(REC_US)) rtc_core_properties_inst (.mclk_i, .nrst_i, .scl_i,
	.sda_oe_o, .osc_i, .vcc_ok_i, .backup_power_o, .access_enabled_o, .wave_or_ref_pin_oe_o);
`default_nettype wire

// >>> testbench/rtc_core_tb.sv
// Self-checking bench of the clock/calendar register core
`timescale 1ns/1ps
`default_nettype none
module rtc_core_tb;
	import rtc_pkg::*;
	localparam int unsigned REC_US = 1;
	localparam int unsigned REC_CYC = REC_US * 1000 / 20;
	logic mclk_i, nrst_i, scl_i, m_sda, osc_i, vcc_ok_i, vcc_gt_bat_i;
	logic sda_o, sda_oe_o, backup_power_o, access_enabled_o, wave_or_ref_pin_o, wave_or_ref_pin_oe_o;
	// Pull-up on the data wire: low when either side pulls
	wire sda_i = m_sda & ~sda_oe_o;
	int mismatches, checked;
	logic [7:0] q, v, mn, yr;
	logic [7:0] rd [8];
	logic [7:0] ex [$];
	logic [7:0] wv [$];
	logic ack;
	rtc_core #(.REC_US(REC_US)) rtc_core_inst (.mclk_i, .nrst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .osc_i,
		.vcc_ok_i, .vcc_gt_bat_i, .backup_power_o, .access_enabled_o, .wave_or_ref_pin_o, .wave_or_ref_pin_oe_o);
	rtc_i2c_master mst (.mclk_i, .sda_i, .scl_o(scl_i), .sda_o(m_sda));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Leap year of a two-digit BCD year: its value divisible by four
	function automatic logic leap_yr(input logic [7:0] y);
		return ((y[7:4] * 10 + y[3:0]) % 4) == 0;
	endfunction
	task automatic nw(input int n);
		repeat (n) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask
	task automatic wr(input logic [5:0] p, input logic [7:0] d [$]);
		mst.start();
		mst.xfer(DEV_ADDR, 1'b1, q, ack);
		chk(8'(ack), 8'h01);
		mst.xfer({2'b00, p}, 1'b1, q, ack);
		foreach (d[i]) mst.xfer(d[i], 1'b1, q, ack);
		mst.stop();
	endtask
	task automatic rdn(input logic [5:0] p, input int n);
		mst.start();
		mst.xfer(DEV_ADDR, 1'b1, q, ack);
		mst.xfer({2'b00, p}, 1'b1, q, ack);
		mst.start();
		mst.xfer(DEV_ADDR | 8'h01, 1'b1, q, ack);
		for (int i = 0; i < n; i++) mst.xfer(8'hFF, i == n - 1, rd[i], ack);
		mst.stop();
	endtask
	task automatic end_sim();
		if (mismatches == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	initial begin
		// About 74k cycles of tests, dominated by the one-second run
		#1_800_000;
		mismatches++;
		end_sim();
	end
	initial begin
		nrst_i = 1'b0;
		osc_i = 1'b0;
		vcc_ok_i = 1'b0;
		vcc_gt_bat_i = 1'b0;
		mismatches = 0;
		checked = 0;
		v = 8'($urandom(77665));
		repeat (20) @(posedge mclk_i);
		nrst_i <= 1'b1;
		nw(30);
		chk(8'(access_enabled_o), 8'h00);
		chk(8'(backup_power_o), 8'h00);
		@(posedge mclk_i);
		vcc_ok_i <= 1'b1;
		nw(REC_CYC - 10);
		chk(8'(access_enabled_o), 8'h00);
		nw(30);
		chk(8'(access_enabled_o), 8'h01);
		ex = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'hBF};
		rdn(6'h00, 8);
		foreach (ex[i]) chk(rd[i], ex[i]);
		// Multibyte write running over the top of RAM into the seconds
		v = 8'($urandom);
		ex = '{v, ~v, v ^ 8'h5A, 8'h12};
		wr(6'h3D, ex);
		rdn(6'h3D, 4);
		foreach (ex[i]) chk(rd[i], ex[i]);
		// Legal digits with every fixed-zero bit set, 12-hour PM 11
		mn = {1'b1, 3'($urandom_range(0, 5)), 4'($urandom_range(0, 9))};
		yr = {4'($urandom_range(0, 9)), 4'($urandom_range(0, 9))};
		wv = '{mn, 8'hF1, 8'hFD, 8'hE8, 8'hF2, yr};
		ex = '{mn & 8'h7F, 8'h71, 8'h05, 8'h28, 8'h12, yr};
		wr(6'h01, wv);
		rdn(6'h01, 6);
		foreach (ex[i]) chk(rd[i], ex[i]);
		wr(6'h07, '{8'h93});
		wr(6'h07, '{8'hB3});
		rdn(6'h07, 1);
		chk(rd[0], 8'h93);
		// Pulse under the filter width, then a steady level
		v = 8'($urandom_range(20, 230));
		@(posedge mclk_i);
		osc_i <= 1'b1;
		nw(v);
		chk(8'(wave_or_ref_pin_oe_o), 8'h01);
		@(posedge mclk_i);
		osc_i <= 1'b0;
		nw(300);
		@(posedge mclk_i);
		osc_i <= 1'b1;
		nw(300);
		chk(8'(wave_or_ref_pin_oe_o), 8'h00);
		@(posedge mclk_i);
		osc_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			if (v[7:1] == DEV_ADDR[7:1]) v[1] = ~v[1];
			mst.start();
			mst.xfer(v, 1'b1, q, ack);
			chk(8'(ack), 8'h00);
			mst.stop();
		end
		// Supply lost in the middle of a data byte
		v = 8'($urandom);
		wr(6'h08, '{v});
		mst.start();
		mst.xfer(DEV_ADDR, 1'b1, q, ack);
		mst.xfer(8'h08, 1'b1, q, ack);
		fork
			mst.xfer(~v, 1'b1, q, ack);
			begin
				repeat (30) @(posedge mclk_i);
				vcc_ok_i <= 1'b0;
			end
		join
		nw(2);
		chk(8'(sda_oe_o), 8'h00);
		chk(8'(access_enabled_o), 8'h00);
		chk(8'(backup_power_o), 8'h01);
		@(posedge mclk_i);
		vcc_gt_bat_i <= 1'b1;
		nw(5);
		chk(8'(backup_power_o), 8'h00);
		mst.stop();
		@(posedge mclk_i);
		vcc_ok_i <= 1'b1;
		nw(REC_CYC + 30);
		rdn(6'h08, 1);
		chk(rd[0], v);
		// Last second before midnight, 11 PM in 12-hour mode, 28 February
		yr = {4'($urandom_range(0, 9)), 4'($urandom_range(0, 9))};
		wr(6'h00, '{8'h59, 8'h59, 8'h71, 8'h07, 8'h28, 8'h02, yr});
		// Supply off disables the filter, so a fast oscillator runs one full second through the chain
		@(posedge mclk_i);
		vcc_ok_i <= 1'b0;
		nw(4);
		repeat (65700) begin
			@(posedge mclk_i);
			osc_i <= ~osc_i;
		end
		@(posedge mclk_i);
		vcc_ok_i <= 1'b1;
		nw(REC_CYC + 30);
		rdn(6'h00, 7);
		ex = '{8'h00, 8'h00, 8'h52, 8'h01, leap_yr(yr) ? 8'h29 : 8'h01, leap_yr(yr) ? 8'h02 : 8'h03, yr};
		foreach (ex[i]) chk(rd[i], ex[i]);
		wr(6'h00, '{8'h80});
		rdn(6'h00, 8);
		chk(rd[0], 8'h80);
		chk(rd[7], 8'hB3);
		// Wave off with the level bit high releases the pin; 1Hz starts low after a seconds write
		wr(6'h07, '{8'h80});
		nw(4);
		chk(8'(wave_or_ref_pin_oe_o), 8'h00);
		wr(6'h07, '{8'h10});
		nw(4);
		chk(8'(wave_or_ref_pin_oe_o), 8'h01);
		chk(8'({sda_o, wave_or_ref_pin_o}), 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire

// >>> testbench/rtc_i2c_master.sv
// Serial bus master model; one bit is 8 system clocks, clock idles high
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_master (
	input  wire logic mclk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// Raises data, then the clock, then pulls data low while the clock is high
	task automatic start();
		cyc(4);
		sda_o <= 1'b1;
		cyc(2);
		scl_o <= 1'b1;
		cyc(4);
		sda_o <= 1'b0;
		cyc(4);
		scl_o <= 1'b0;
	endtask
	task automatic stop();
		cyc(2);
		sda_o <= 1'b0;
		cyc(3);
		scl_o <= 1'b1;
		cyc(4);
		sda_o <= 1'b1;
		cyc(4);
	endtask
	// Eight data bits then the acknowledge bit; sampled late in the high phase
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			cyc(2);
			sda_o <= (i > 0) ? d[i-1] : last;
			cyc(3);
			scl_o <= 1'b1;
			cyc(3);
			if (i > 0) q[i-1] = sda_i;
			else ack = !sda_i;
			scl_o <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire
